// file: lbm_top.sv
// Leaky bucket activity monitor with register port and interrupt.
`timescale 1ns/1ns
module lbm_top
  import lbm_pkg::*;
#(
  parameter longint CYCLE_CLKS = lbm_pkg::LBM_CYCLE_CLKS
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       fail_i,
  input  wire logic       erratic_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            alarm_o,
  output logic            irq_o
);
  import lbm_pkg::*;

  // ****************************************************************
  // Input synchronisers and observation cycle.
  // ****************************************************************
  logic [1:0]  fail_sync_reg;
  logic [1:0]  err_sync_reg;
  logic [31:0] cyc_reg;
  logic [31:0] cyc_next;
  logic        seen_reg;
  logic        seen_next;
  logic        tick;
  logic        bad;

  // Cycle counter and bad-event latch for the current cycle.
  // The verdict handed to the bucket includes the tick clock itself, so a fault
  // seen only in the last clock of a cycle still marks that cycle bad.
  always_comb begin
    tick      = (cyc_reg == 32'(CYCLE_CLKS - 1));
    cyc_next  = tick ? 32'h0 : cyc_reg + 32'h1;
    bad       = seen_reg | fail_sync_reg[1] | err_sync_reg[1];
    seen_next = tick ? 1'b0 : bad;
  end

  // Registers of the observation timing.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fail_sync_reg <= 2'h0;
      err_sync_reg  <= 2'h0;
      cyc_reg       <= 32'h0;
      seen_reg      <= 1'b0;
    end else begin
      fail_sync_reg <= {fail_sync_reg[0], fail_i};
      err_sync_reg  <= {err_sync_reg[0], erratic_i};
      cyc_reg       <= cyc_next;
      seen_reg      <= seen_next;
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [7:0] cfg_reg  [8];
  logic [7:0] cfg_next [8];
  logic       sel_reg;
  logic       sel_next;
  logic [1:0] en_reg;
  logic [1:0] en_next;
  logic [1:0] stat_reg;
  logic [1:0] stat_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] level;
  logic       alarm;
  logic       alarm_d_reg;
  logic [1:0] ev;
  logic       b;

  // Register writes, reads and sticky status.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    sel_next   = sel_reg;
    en_next    = en_reg;
    rdata_next = 8'h00;
    ev         = {alarm_d_reg & ~alarm, alarm & ~alarm_d_reg};
    stat_next  = stat_reg;
    if (wr_i) begin
      if (addr_i >= LBM_OFS_SET_LVL0 && addr_i <= LBM_OFS_DECAY1) begin
        cfg_next[3'(addr_i - LBM_OFS_SET_LVL0)] = wdata_i;
      end
      if (addr_i == LBM_OFS_IRQ_CLR) begin
        stat_next = stat_reg & ~wdata_i[1:0];
      end
      if (addr_i == LBM_OFS_IRQ_EN) begin
        en_next = wdata_i[1:0];
      end
      if (addr_i == LBM_OFS_CFG_SEL) begin
        sel_next = wdata_i[0];
      end
    end
    stat_next = stat_next | ev; // Set wins over clear.
    if (rd_i) begin
      if (addr_i >= LBM_OFS_SET_LVL0 && addr_i <= LBM_OFS_DECAY1) begin
        rdata_next = cfg_reg[3'(addr_i - LBM_OFS_SET_LVL0)];
      end else if (addr_i == LBM_OFS_LEVEL) begin
        rdata_next = level;
      end else if (addr_i == LBM_OFS_IRQ_STAT) begin
        rdata_next = {6'h00, stat_reg};
      end else if (addr_i == LBM_OFS_IRQ_EN) begin
        rdata_next = {6'h00, en_reg};
      end else if (addr_i == LBM_OFS_CFG_SEL) begin
        rdata_next = {7'h00, sel_reg};
      end
    end
    if (addr_i == LBM_OFS_DECAY0 || addr_i == LBM_OFS_DECAY1) begin
      rdata_next = rdata_next & 8'h03; // Upper decay bits are unused.
    end
  end

  // Register file flops with documented defaults.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < 2; k++) begin
        cfg_reg[4*k]   <= LBM_RST_SET_LVL;
        cfg_reg[4*k+1] <= LBM_RST_LOW_LVL;
        cfg_reg[4*k+2] <= LBM_RST_SIZE;
        cfg_reg[4*k+3] <= LBM_RST_DECAY;
      end
      sel_reg     <= 1'b0;
      en_reg      <= 2'h0;
      stat_reg    <= 2'h0;
      rdata_reg   <= 8'h00;
      alarm_d_reg <= 1'b0;
    end else begin
      for (int j = 0; j < 8; j++) begin
        cfg_reg[j] <= cfg_next[j];
      end
      sel_reg     <= sel_next;
      en_reg      <= en_next;
      stat_reg    <= stat_next;
      rdata_reg   <= rdata_next;
      alarm_d_reg <= alarm;
    end
  end

  // ****************************************************************
  // Bucket for the selected configuration.
  // ****************************************************************
  assign b = sel_reg;

  lbm_bucket u_bucket (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .bad_i     (bad),
    .decay_i   (cfg_reg[{b, 2'h3}][1:0]),
    .size_i    (cfg_reg[{b, 2'h2}]),
    .set_lvl_i (cfg_reg[{b, 2'h0}]),
    .low_lvl_i (cfg_reg[{b, 2'h1}]),
    .level_o   (level),
    .alarm_o   (alarm)
  );

  assign rdata_o = rdata_reg;
  assign alarm_o = alarm;
  assign irq_o   = |(stat_reg & en_reg);

  a_set_lvl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == LBM_OFS_SET_LVL1) |=> (cfg_reg[4] == $past(wdata_i)))
    else $error("Set level of configuration 1 not stored.");
endmodule : lbm_top

// file: lbm_pkg.sv
// Package of constants for the leaky bucket activity monitor.
package lbm_pkg;
  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] LBM_OFS_LOW_LVL0   = 8'h51;
  localparam logic [7:0] LBM_OFS_SIZE0      = 8'h52;
  localparam logic [7:0] LBM_OFS_DECAY0     = 8'h53;
  localparam logic [7:0] LBM_OFS_SET_LVL1   = 8'h54;
  localparam logic [7:0] LBM_OFS_SET_LVL0   = 8'h50;
  localparam logic [7:0] LBM_OFS_LOW_LVL1   = 8'h55;
  localparam logic [7:0] LBM_OFS_SIZE1      = 8'h56;
  localparam logic [7:0] LBM_OFS_DECAY1     = 8'h57;
  localparam logic [7:0] LBM_OFS_LEVEL      = 8'h60;
  localparam logic [7:0] LBM_OFS_IRQ_STAT   = 8'h61;
  localparam logic [7:0] LBM_OFS_IRQ_CLR    = 8'h62;
  localparam logic [7:0] LBM_OFS_IRQ_EN     = 8'h63;
  localparam logic [7:0] LBM_OFS_CFG_SEL    = 8'h64;
  // ****************************************************************
  // Reset values and fields.
  // ****************************************************************
  localparam logic [7:0] LBM_RST_DECAY      = 8'h01;
  localparam logic [7:0] LBM_RST_SIZE       = 8'h08;
  localparam logic [7:0] LBM_RST_SET_LVL    = 8'h06;
  localparam logic [7:0] LBM_RST_LOW_LVL    = 8'h04;
  localparam int         LBM_DECAY_W        = 2;
  localparam int         LBM_IRQ_RAISE      = 0;
  localparam int         LBM_IRQ_CLEAR      = 1;
  localparam int         LBM_IRQ_W          = 2;
  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int         LBM_CLK_MHZ        = 250;
  localparam int         LBM_CYCLE_MS       = 128;
  localparam longint     LBM_CYCLE_CLKS     = longint'(LBM_CYCLE_MS) * 1000 * LBM_CLK_MHZ;
endpackage : lbm_pkg

// file: lbm_bucket.sv
// One leaky bucket accumulator with its alarm.
`timescale 1ns/1ns
module lbm_bucket (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       bad_i,
  input  wire logic [1:0] decay_i,
  input  wire logic [7:0] size_i,
  input  wire logic [7:0] set_lvl_i,
  input  wire logic [7:0] low_lvl_i,
  output logic      [7:0] level_o,
  output logic            alarm_o
);
  logic [7:0] level_reg;
  logic [7:0] level_next;
  logic [3:0] good_reg;
  logic [3:0] good_next;
  logic       alarm_reg;
  logic       alarm_next;
  logic [3:0] period;

  // Fill and decay once per observation cycle; size clamp and alarm every clock.
  always_comb begin
    period     = 4'h1 << decay_i;
    level_next = level_reg;
    good_next  = good_reg;
    alarm_next = alarm_reg;
    if (tick_i) begin
      if (bad_i) begin
        good_next = 4'h0;
        if (level_reg < size_i) begin
          level_next = level_reg + 8'h01;
        end
      end else if (good_reg + 4'h1 >= period) begin
        good_next = 4'h0;
        if (level_reg != 8'h00) begin
          level_next = level_reg - 8'h01;
        end
      end else begin
        good_next = good_reg + 4'h1;
      end
    end
    if (level_reg > size_i) begin
      level_next = size_i;
    end
    if (level_reg >= set_lvl_i) begin
      alarm_next = 1'b1;
    end else if (level_reg <= low_lvl_i) begin
      alarm_next = 1'b0;
    end
  end

  // Bucket state registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_reg <= 8'h00;
      good_reg  <= 4'h0;
      alarm_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
      good_reg  <= good_next;
      alarm_reg <= alarm_next;
    end
  end

  assign level_o = level_reg;
  assign alarm_o = alarm_reg;

  a_bad_adds_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_i && bad_i && level_reg < size_i) |=> (level_reg == $past(level_reg) + 8'h01))
    else $error("Bad cycle did not add one.");
  a_size_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_i && bad_i && level_reg == size_i) |=> (level_reg == $past(level_reg)))
    else $error("Accumulator passed bucket size.");
  a_floor_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (level_reg == 8'h00 && !(tick_i && bad_i)) |=> (level_reg == 8'h00))
    else $error("Accumulator went below zero.");
  a_decay_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_i && !bad_i && good_reg + 4'h1 >= period && level_reg != 8'h00
     && level_reg <= size_i) |=> (level_reg == $past(level_reg) - 8'h01))
    else $error("Decay did not remove one.");
  a_period_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (decay_i == 2'h3) |-> (period == 4'h8))
    else $error("Decay code three is not eight cycles.");
  a_no_early_decay: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_i && !bad_i && good_reg + 4'h1 < period) |=> (level_reg == $past(level_reg)
     || $past(level_reg) > $past(size_i)))
    else $error("Decay came before its period.");
  a_alarm_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (alarm_reg && level_reg > low_lvl_i && level_reg < set_lvl_i) |=> alarm_reg)
    else $error("Alarm cleared above lower threshold.");
endmodule : lbm_bucket

// file: lbm_top_tb.sv
// Self-checking testbench for the leaky bucket activity monitor.
`timescale 1ns/1ns
module lbm_top_tb;
  import lbm_pkg::*;
  // ****************************************************************
  // Signals and design instance.
  // ****************************************************************
  localparam int TICK = 10;
  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        fail_i       = 1'b0;
  logic        erratic_i    = 1'b0;
  logic [7:0]  addr_i       = 8'h00;
  logic [7:0]  wdata_i      = 8'h00;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic [7:0]  rdata_o;
  logic        alarm_o;
  logic        irq_o;
  int          fail_count   = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  logic [31:0] lfsr         = 32'h000101D8;

  // The short observation cycle keeps the whole run to under a thousand clocks.
  lbm_top #(.CYCLE_CLKS(TICK)) lbm_top_inst (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .fail_i    (fail_i),
    .erratic_i (erratic_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rdata_o   (rdata_o),
    .alarm_o   (alarm_o),
    .irq_o     (irq_o)
  );

  // The clock toggles every half period of 2 ns.
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Steps the pseudo-random sequence by one.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Gives the reset value of a configuration register from its low offset bits.
  function automatic logic [7:0] dflt(input logic [1:0] k);
    case (k)
      2'h0: return 8'h06;
      2'h1: return 8'h04;
      2'h2: return 8'h08;
      default: return 8'h01;
    endcase
  endfunction : dflt

  // Rounds a measured gap to whole observation cycles, absorbing polling slack.
  function automatic logic [7:0] to_ticks(input int gap);
    return 8'((gap + TICK / 2) / TICK * TICK);
  endfunction : to_ticks

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just inside it.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // Polls the level until it moves, counting clocks; two clocks per read.
  task automatic wait_change(input logic [7:0] old, output logic [7:0] now, output int gap);
    gap = 0;
    now = old;
    while (now === old && gap < 400) begin
      rd(LBM_OFS_LEVEL, now);
      gap += 2;
    end
  endtask : wait_change

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      $display("mismatch timeout expected done seen hang");
      end_sim();
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    logic [7:0] v;
    logic [7:0] lvl;
    int         gap;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(8'h50 + 8'(i), v);
      chk("config default", dflt(i[1:0]), v);
    end
    rd(8'h80 | lfsr[7:0], v);
    chk("unmapped read", 8'h00, v);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(LBM_OFS_SET_LVL1, lfsr[7:0]);
      rd(LBM_OFS_SET_LVL1, v);
      chk("set level cfg1", lfsr[7:0], v);
    end
    wr(LBM_OFS_DECAY0, lfsr[15:8]);
    rd(LBM_OFS_DECAY0, v);
    chk("decay readback", lfsr[15:8] & 8'h03, v);
    $display("test registers done");
    wr(LBM_OFS_IRQ_EN, 8'h01);
    fail_i <= 1'b1;
    lvl = 8'h00;
    for (int i = 1; i <= 8; i++) begin
      wait_change(lvl, lvl, gap);
      chk("level rise", 8'(i), lvl);
      if (i > 1) chk("fill period", 8'(TICK), to_ticks(gap));
      if (i == 4) begin
        fail_i    <= 1'b0;
        erratic_i <= 1'b1;
      end
    end
    repeat (4 * TICK) @(posedge clk_i);
    rd(LBM_OFS_LEVEL, v);
    chk("level held at size", 8'h08, v);
    chk("alarm raised", 8'h01, {7'h00, alarm_o});
    chk("irq enabled", 8'h01, {7'h00, irq_o});
    wr(LBM_OFS_IRQ_EN, 8'h02);
    wr(LBM_OFS_IRQ_CLR, 8'h03);
    rd(LBM_OFS_IRQ_STAT, v);
    chk("status cleared", 8'h00, v);
    chk("irq masked", 8'h00, {7'h00, irq_o});
    $display("test fill done");
    erratic_i <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(LBM_OFS_DECAY0, 8'(d));
      wait_change(lvl, lvl, gap);
      wait_change(lvl, v, gap);
      chk("level fall", lvl - 8'h01, v);
      chk("decay period", 8'(TICK << d), to_ticks(gap));
      chk("alarm level", {7'h00, v > 8'h04}, {7'h00, alarm_o});
      lvl = v;
    end
    repeat (32 * TICK) @(posedge clk_i);
    rd(LBM_OFS_LEVEL, v);
    chk("level floor", 8'h00, v);
    rd(LBM_OFS_IRQ_STAT, v);
    chk("status clear event", 8'h02, v);
    chk("irq on clear", 8'h01, {7'h00, irq_o});
    $display("test decay done");
    // Configuration 1 takes over the bucket with a low alarm set level.
    wr(LBM_OFS_SET_LVL1, 8'h02);
    wr(LBM_OFS_CFG_SEL, 8'h01);
    rd(LBM_OFS_CFG_SEL, v);
    chk("config select", 8'h01, v);
    fail_i <= 1'b1;
    lvl = 8'h00;
    for (int i = 1; i <= 2; i++) begin
      wait_change(lvl, lvl, gap);
      chk("cfg1 level rise", 8'(i), lvl);
    end
    chk("cfg1 alarm raised", 8'h01, {7'h00, alarm_o});
    fail_i <= 1'b0;
    $display("test config 1 done");
    end_sim();
  end
endmodule : lbm_top_tb
